// ===== src/csrs_pkg.sv
// Purpose: shared constants and types of the chip-select route and stretch
// Assumes: apb register bus with 32-bit data, one word per register
// Notes:   register byte address is four times the register index

package csrs_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam int         APB_AW        = 12;
  localparam logic [7:0] IDX_STRETCH   = 8'h5a;
  localparam logic [7:0] IDX_GEN1_CTRL = 8'h5d;
  localparam logic [7:0] IDX_GEN2_CTRL = 8'h5f;
  localparam logic [7:0] IDX_STATUS    = 8'h60;

  localparam logic [APB_AW-1:0] ADDR_STRETCH   = {2'h0, IDX_STRETCH, 2'h0};
  localparam logic [APB_AW-1:0] ADDR_GEN1_CTRL = {2'h0, IDX_GEN1_CTRL, 2'h0};
  localparam logic [APB_AW-1:0] ADDR_GEN2_CTRL = {2'h0, IDX_GEN2_CTRL, 2'h0};
  localparam logic [APB_AW-1:0] ADDR_STATUS    = {2'h0, IDX_STATUS, 2'h0};

  // ****************************************
  // field positions and reset values
  // ****************************************
  localparam int G1_DRIVES_G2_BIT   = 7;
  localparam int G1_DRIVES_PROG_BIT = 6;
  localparam int G1_POL_BIT         = 5;
  localparam int G2_DRIVES_PROG_BIT = 6;
  localparam int G2_POL_BIT         = 5;

  localparam logic [7:0] STRETCH_RESET = 8'h00;
  localparam logic       CTRL_BIT_RESET = 1'b0;
  localparam logic [1:0] STRETCH_NONE  = 2'h0;
  localparam logic       POL_LOW       = 1'b0;

  // ****************************************
  // timing
  // ****************************************
  localparam int ECLK_HALF_DEFAULT = 2;

  // ****************************************
  // types
  // ****************************************
  typedef struct packed {
    logic io;
    logic gen1;
    logic gen2;
    logic prog;
  } csrs_sel_t;

  typedef struct packed {
    logic [1:0] io_stretch_count;
    logic [1:0] gen1_stretch_count;
    logic [1:0] gen2_stretch_count;
    logic [1:0] program_stretch_count;
  } csrs_stretch_t;

  typedef struct packed {
    logic gen1_drives_gen2;
    logic gen1_drives_program_sel;
    logic gen2_drives_program_sel;
    logic gen1_polarity;
    logic gen2_polarity;
  } csrs_route_t;

  typedef struct packed {
    logic program_select_pin;
    logic general_select_one_pin;
    logic general_select_two_pin;
    logic io_select_pin;
  } csrs_pins_t;

  localparam csrs_pins_t PINS_RESET = 4'hf;

  typedef struct packed {
    logic              eclk;
    logic              stretching;
    logic [1:0]        stretch_left;
    csrs_sel_t         claim;
  } csrs_status_t;

  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [APB_AW-1:0] paddr;
    logic [31:0]       pwdata;
  } csrs_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } csrs_apb_rsp_t;

  typedef enum logic {ECLK_LOW, ECLK_HIGH} csrs_eclk_state_t;

  typedef enum logic [2:0] {
    REG_NONE, REG_STRETCH, REG_GEN1, REG_GEN2, REG_STATUS
  } csrs_reg_sel_t;

endpackage : csrs_pkg

// ===== src/csrs_eclk_gen.sv
// Purpose: bus phase clock divider with high-phase stretching
// Assumes: stretch count is steady from cycle start to the rising phase
// Notes:   timer tick runs from its own divider so stretching never halts it

`timescale 1ns/1ps

module csrs_eclk_gen #(
  parameter int HALF = csrs_pkg::ECLK_HALF_DEFAULT
) (
  input  wire logic       i_ref_clk,
  input  wire logic       i_reset,
  input  wire logic [1:0] i_stretch_count,
  output logic            o_eclk,
  output logic            o_cycle_start,
  output logic            o_stretching,
  output logic [1:0]      o_stretch_left,
  output logic            o_timer_tick
);

  localparam int CW = $clog2(2 * HALF + 1);
  localparam logic [CW-1:0] HALF_LAST = CW'(HALF - 1);
  localparam logic [CW-1:0] FULL_LAST = CW'(2 * HALF - 1);

  typedef struct packed {
    csrs_pkg::csrs_eclk_state_t phase;
    logic [CW-1:0]              cnt;
    logic [1:0]                 left;
    logic                       stretching;
    logic [CW-1:0]              tick_cnt;
    logic                       tick;
    logic                       start;
  } csrs_eclk_st_t;

  csrs_eclk_st_t st_reg;
  csrs_eclk_st_t st_next;

  always_comb begin
    st_next       = st_reg;
    st_next.tick  = 1'b0;
    st_next.start = 1'b0;
    // free-running nominal cycle tick for timers and baud [R11]
    if (st_reg.tick_cnt == FULL_LAST) begin
      st_next.tick_cnt = '0;
      st_next.tick     = 1'b1;
    end else begin
      st_next.tick_cnt = st_reg.tick_cnt + CW'(1);
    end
    case (st_reg.phase)
      csrs_pkg::ECLK_LOW: begin
        if (st_reg.cnt == HALF_LAST) begin
          st_next.phase = csrs_pkg::ECLK_HIGH;
          st_next.cnt   = '0;
          st_next.left  = i_stretch_count; // [R9]
        end else begin
          st_next.cnt = st_reg.cnt + CW'(1);
        end
      end
      csrs_pkg::ECLK_HIGH: begin
        if (st_reg.cnt == (st_reg.stretching ? FULL_LAST : HALF_LAST)) begin
          st_next.cnt = '0;
          if (st_reg.left != csrs_pkg::STRETCH_NONE) begin
            // each extra bus cycle keeps the clock high a full period [R9]
            st_next.left       = st_reg.left - 2'h1;
            st_next.stretching = 1'b1;
          end else begin
            st_next.phase      = csrs_pkg::ECLK_LOW;
            st_next.stretching = 1'b0;
            st_next.start      = 1'b1;
          end
        end else begin
          st_next.cnt = st_reg.cnt + CW'(1);
        end
      end
      default: begin
        st_next = '0;
      end
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_eclk         = (st_reg.phase == csrs_pkg::ECLK_HIGH);
  assign o_cycle_start  = st_reg.start;
  assign o_stretching   = st_reg.stretching;
  assign o_stretch_left = st_reg.left;
  assign o_timer_tick   = st_reg.tick;

endmodule : csrs_eclk_gen

// ===== src/csrs_top.sv
// Purpose: chip-select output routing and bus phase clock stretching
// Assumes: range hits and access come from logic on i_ref_clk
// Notes:   apb slave, zero wait states, unmapped address answers pslverr
//
// Notes on behaviour
// [R1] - all eight drive-bit settings give a defined pin outcome
// [R2] - fixed priority among ranges still picks the claiming select
// [R3] - gen2 drives program: gen2 ored into program pin, gen2 pin idle
// [R4] - gen1 drives program: gen1 ored into program pin, gen1 pin idle
// [R5] - gen1 drives gen2 alone: gen2 pin serves both general areas
// [R6] - gen1-to-gen2 plus gen2-to-program: gen1 own area, gen2 pin idle
// [R7] - both drive program: program pin serves all three areas
// [R8] - chip-select pins change only in step with the bus phase clock
// [R9] - nonzero count holds bus clock high that many extra cycles
// [R10] - stretch only on accesses inside that select's range
// [R11] - timer and baud ticks keep running during a stretch
// [R12] - stretch register: io 7:6, gen1 5:4, gen2 3:2, program 1:0
// [R13] - field value is binary count of extra cycles, 0 to 3
// [R14] - stretch fields clear to zero at reset
// [R15] - drive bits at gen1 control 7 and 6, gen2 control 6
// [R16] - polarity bit 0 active low, 1 active high, merged pins too
// [R17] - stretch count comes from the claiming select before merging
// [R18] - software keeps chip-select ranges apart
//
// The APB interface to the registers is this design's own decision.

`timescale 1ns/1ps

module csrs_top #(
  parameter int ECLK_HALF = csrs_pkg::ECLK_HALF_DEFAULT
) (
  input  wire logic                i_ref_clk,
  input  wire logic                i_reset,
  input  wire csrs_pkg::csrs_apb_req_t i_apb,
  output csrs_pkg::csrs_apb_rsp_t  o_apb,
  input  wire logic                i_access,
  input  wire csrs_pkg::csrs_sel_t i_range_hit,
  output logic                     o_eclk,
  output logic                     o_bus_cycle_start,
  output logic                     o_timer_tick,
  output csrs_pkg::csrs_pins_t     o_pins
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    csrs_pkg::csrs_stretch_t stretch;
    csrs_pkg::csrs_route_t   route;
    csrs_pkg::csrs_sel_t     claim;
    csrs_pkg::csrs_pins_t    pins;
    logic [31:0]             prdata;
    logic                    pslverr;
  } csrs_top_st_t;

  csrs_top_st_t st_reg;
  csrs_top_st_t st_next;

  logic       eclk;
  logic       cycle_start;
  logic       stretching;
  logic [1:0] stretch_left;
  logic       timer_tick;
  logic [1:0] cycle_stretch;

  // ****************************************
  // functions
  // ****************************************

  // address decode, shared by read and write paths
  function automatic csrs_pkg::csrs_reg_sel_t decode_addr(
    input logic [csrs_pkg::APB_AW-1:0] addr
  );
    csrs_pkg::csrs_reg_sel_t r;
    r = csrs_pkg::REG_NONE;
    case (addr)
      csrs_pkg::ADDR_STRETCH:   r = csrs_pkg::REG_STRETCH;
      csrs_pkg::ADDR_GEN1_CTRL: r = csrs_pkg::REG_GEN1;
      csrs_pkg::ADDR_GEN2_CTRL: r = csrs_pkg::REG_GEN2;
      csrs_pkg::ADDR_STATUS:    r = csrs_pkg::REG_STATUS;
      default:                  r = csrs_pkg::REG_NONE;
    endcase
    return r;
  endfunction : decode_addr

  // one winner among raw range hits; io first, program last
  // so the boot area never shadows a more specific select
  function automatic csrs_pkg::csrs_sel_t resolve_claim(
    input csrs_pkg::csrs_sel_t hit
  );
    csrs_pkg::csrs_sel_t c;
    c = '0;
    if (hit.io) begin
      c.io = 1'b1;
    end else if (hit.gen1) begin
      c.gen1 = 1'b1;
    end else if (hit.gen2) begin
      c.gen2 = 1'b1;
    end else if (hit.prog) begin
      c.prog = 1'b1;
    end
    return c;
  endfunction : resolve_claim

  // count of the claiming select, taken before any merging
  function automatic logic [1:0] stretch_of(
    input csrs_pkg::csrs_sel_t     c,
    input csrs_pkg::csrs_stretch_t s
  );
    logic [1:0] n;
    n = csrs_pkg::STRETCH_NONE;
    if (c.io) begin
      n = s.io_stretch_count;
    end else if (c.gen1) begin
      n = s.gen1_stretch_count;
    end else if (c.gen2) begin
      n = s.gen2_stretch_count;
    end else if (c.prog) begin
      n = s.program_stretch_count;
    end
    return n;
  endfunction : stretch_of

  // pin level from assertion and polarity bit
  function automatic logic pin_level(
    input logic asserted,
    input logic pol
  );
    return (pol == csrs_pkg::POL_LOW) ? ~asserted : asserted;
  endfunction : pin_level

  // merge claimed selects onto pins
  function automatic csrs_pkg::csrs_pins_t route_pins(
    input csrs_pkg::csrs_sel_t   c,
    input csrs_pkg::csrs_route_t r
  );
    csrs_pkg::csrs_pins_t p;
    logic prog_a;
    logic gen1_a;
    logic gen2_a;
    logic g1_to_g2;
    // program pin collects whichever generals are routed to it [R3] [R4]
    prog_a = c.prog
           | (r.gen1_drives_program_sel & c.gen1)
           | (r.gen2_drives_program_sel & c.gen2); // [R7]
    // gen1-to-gen2 only counts while gen1 is not sent to program [R4]
    g1_to_g2 = r.gen1_drives_gen2 & ~r.gen1_drives_program_sel;
    // gen2 pin silent whenever gen2 drives program [R3] [R6]
    gen2_a = ~r.gen2_drives_program_sel
           & (c.gen2 | (g1_to_g2 & c.gen1)); // [R5]
    // gen1 pin keeps its area unless moved to program or to a live
    // gen2 pin; with gen2 sent to program gen1 stays on its own [R6]
    gen1_a = c.gen1 & ~r.gen1_drives_program_sel
           & ~(g1_to_g2 & ~r.gen2_drives_program_sel); // [R5]
    // merged outputs follow the polarity of the pin they land on [R16]
    p.program_select_pin     = pin_level(prog_a, csrs_pkg::POL_LOW);
    p.general_select_one_pin = pin_level(gen1_a, r.gen1_polarity);
    p.general_select_two_pin = pin_level(gen2_a, r.gen2_polarity);
    p.io_select_pin          = pin_level(c.io, csrs_pkg::POL_LOW);
    return p;
  endfunction : route_pins

  // read value of one register
  function automatic logic [7:0] read_byte(
    input csrs_pkg::csrs_reg_sel_t sel,
    input csrs_top_st_t            s,
    input csrs_pkg::csrs_status_t  stat
  );
    logic [7:0] b;
    b = '0;
    case (sel)
      csrs_pkg::REG_STRETCH: begin
        b = s.stretch;
      end
      csrs_pkg::REG_GEN1: begin
        b[csrs_pkg::G1_DRIVES_G2_BIT]   = s.route.gen1_drives_gen2;
        b[csrs_pkg::G1_DRIVES_PROG_BIT] = s.route.gen1_drives_program_sel;
        b[csrs_pkg::G1_POL_BIT]         = s.route.gen1_polarity;
      end
      csrs_pkg::REG_GEN2: begin
        b[csrs_pkg::G2_DRIVES_PROG_BIT] = s.route.gen2_drives_program_sel;
        b[csrs_pkg::G2_POL_BIT]         = s.route.gen2_polarity;
      end
      csrs_pkg::REG_STATUS: begin
        b = stat;
      end
      default: begin
        b = '0;
      end
    endcase
    return b;
  endfunction : read_byte

  // ****************************************
  // bus phase clock
  // ****************************************

  // the claim about to be latched is used on the start cycle itself,
  // so the count stays with its access even for a one-clock low phase
  assign cycle_stretch = stretch_of(st_next.claim, st_reg.stretch); // [R17]

  csrs_eclk_gen #(
    .HALF(ECLK_HALF)
  ) u_eclk (
    .i_ref_clk      (i_ref_clk),
    .i_reset        (i_reset),
    .i_stretch_count(cycle_stretch),
    .o_eclk         (eclk),
    .o_cycle_start  (cycle_start),
    .o_stretching   (stretching),
    .o_stretch_left (stretch_left),
    .o_timer_tick   (timer_tick)
  );

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    csrs_pkg::csrs_reg_sel_t sel;
    csrs_pkg::csrs_status_t  stat;
    csrs_pkg::csrs_sel_t     claim_new;
    logic                    setup;
    logic                    wr;
    sel       = decode_addr(i_apb.paddr);
    setup     = i_apb.psel & ~i_apb.penable;
    wr        = i_apb.psel & i_apb.penable & i_apb.pwrite;
    claim_new = '0;
    stat.eclk         = eclk;
    stat.stretching   = stretching;
    stat.stretch_left = stretch_left;
    stat.claim        = st_reg.claim;
    st_next = st_reg;

    // read data and error are prepared in setup and held in access
    if (setup) begin
      st_next.prdata  = 32'(read_byte(sel, st_reg, stat));
      st_next.pslverr = (sel == csrs_pkg::REG_NONE);
    end

    if (wr) begin
      case (sel)
        csrs_pkg::REG_STRETCH: begin
          // two-bit binary counts per select [R12] [R13]
          st_next.stretch = csrs_pkg::csrs_stretch_t'(i_apb.pwdata[7:0]);
        end
        csrs_pkg::REG_GEN1: begin
          // every combination accepted as written [R1] [R15]
          st_next.route.gen1_drives_gen2 =
            i_apb.pwdata[csrs_pkg::G1_DRIVES_G2_BIT];
          st_next.route.gen1_drives_program_sel =
            i_apb.pwdata[csrs_pkg::G1_DRIVES_PROG_BIT];
          st_next.route.gen1_polarity =
            i_apb.pwdata[csrs_pkg::G1_POL_BIT];
        end
        csrs_pkg::REG_GEN2: begin
          st_next.route.gen2_drives_program_sel =
            i_apb.pwdata[csrs_pkg::G2_DRIVES_PROG_BIT]; // [R15]
          st_next.route.gen2_polarity =
            i_apb.pwdata[csrs_pkg::G2_POL_BIT];
        end
        default: begin
          // status is read only; unmapped writes already flagged
          st_next.stretch = st_reg.stretch;
        end
      endcase
    end

    // pins and claim move only at a bus cycle boundary, so a
    // register write mid-cycle cannot glitch a select [R8]
    if (cycle_start) begin
      if (i_access) begin
        claim_new = resolve_claim(i_range_hit); // [R2]
      end
      // idle cycles claim nothing, so they never stretch [R10]
      st_next.claim = claim_new;
      st_next.pins  = route_pins(claim_new, st_next.route);
    end
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      st_reg.stretch <= csrs_pkg::STRETCH_RESET; // [R14]
      st_reg.route   <= {5{csrs_pkg::CTRL_BIT_RESET}}; // [R15]
      st_reg.claim   <= '0;
      st_reg.pins    <= csrs_pkg::PINS_RESET;
      st_reg.prdata  <= '0;
      st_reg.pslverr <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  // zero wait states: every access phase completes in its first cycle
  assign o_apb = '{prdata: st_reg.prdata, pready: 1'b1,
                   pslverr: st_reg.pslverr};
  assign o_pins            = st_reg.pins;
  assign o_eclk            = eclk;
  assign o_bus_cycle_start = cycle_start;
  assign o_timer_tick      = timer_tick; // [R11]

endmodule : csrs_top

// ===== tb/csrs_checker.sv
// Purpose: port-level assertions for chip-select routing and stretching
// Assumes: one clock domain, ECLK_HALF handed on by the bind
// Notes:   eclk lengths are counted in reference clocks

`timescale 1ns/1ps

module csrs_checker #(
  parameter int ECLK_HALF = csrs_pkg::ECLK_HALF_DEFAULT
) (
  input wire logic                    i_ref_clk,
  input wire logic                    i_reset,
  input wire csrs_pkg::csrs_apb_req_t i_apb,
  input wire csrs_pkg::csrs_apb_rsp_t o_apb,
  input wire logic                    i_access,
  input wire csrs_pkg::csrs_sel_t     i_range_hit,
  input wire logic                    o_eclk,
  input wire logic                    o_bus_cycle_start,
  input wire logic                    o_timer_tick,
  input wire csrs_pkg::csrs_pins_t    o_pins
);
  localparam int TP = 2 * ECLK_HALF;
  logic [7:0] hi_run;
  logic       idle_cyc;

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);

  // ****************************************
  // helper counters
  // ****************************************
  // length of the current high phase, and whether its cycle had no access
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      hi_run   <= 8'h00;
      idle_cyc <= 1'b0;
    end else begin
      hi_run <= o_eclk ? hi_run + 8'h01 : 8'h00;
      if (o_bus_cycle_start) begin
        idle_cyc <= !i_access;
      end
    end
  end

  sequence s_io_claim;
    o_bus_cycle_start && i_access && i_range_hit.io;
  endsequence
  sequence s_prog_only;
    o_bus_cycle_start && i_access &&
      (i_range_hit == csrs_pkg::csrs_sel_t'(4'h1));
  endsequence

  // ****************************************
  // assertions
  // ****************************************
  tick_period_a: assert property (o_timer_tick |-> ##TP o_timer_tick)
    else $error("timer tick period broken");
  tick_gap_a: assert property (o_timer_tick |=> !o_timer_tick)
    else $error("timer tick longer than one cycle");
  pins_hold_a: assert property (!o_bus_cycle_start |=> $stable(o_pins))
    else $error("pins changed outside a bus cycle start");
  start_on_fall_a: assert property ($fell(o_eclk) |->
      ##[0:1] o_bus_cycle_start)
    else $error("no cycle start at eclk fall");
  start_pulse_a: assert property (o_bus_cycle_start |=> !o_bus_cycle_start)
    else $error("cycle start wider than one cycle");
  high_len_a: assert property ($fell(o_eclk) |->
      (hi_run >= 8'(ECLK_HALF)) &&
      (int'(hi_run) <= ECLK_HALF + 3 * TP) &&
      ((int'(hi_run) - ECLK_HALF) % TP == 0))
    else $error("eclk high phase of illegal length");
  idle_nostretch_a: assert property ($fell(o_eclk) && idle_cyc |->
      hi_run == 8'(ECLK_HALF))
    else $error("cycle without access was stretched");
  io_priority_a: assert property (s_io_claim |=>
      !o_pins.io_select_pin && o_pins.program_select_pin)
    else $error("io claim did not win");
  prog_claim_a: assert property (s_prog_only |=>
      !o_pins.program_select_pin)
    else $error("program area did not assert program pin");
endmodule : csrs_checker

bind csrs_top csrs_checker #(.ECLK_HALF(ECLK_HALF)) chk_u (
  .i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_apb(i_apb), .o_apb(o_apb),
  .i_access(i_access), .i_range_hit(i_range_hit), .o_eclk(o_eclk),
  .o_bus_cycle_start(o_bus_cycle_start), .o_timer_tick(o_timer_tick),
  .o_pins(o_pins));

// ===== tb/csrs_mem_model.sv
// Purpose: external memory that watches its selects during eclk high
// Assumes: selects are only meaningful while eclk is high
// Notes:   reports once per high phase, after eclk falls

`timescale 1ns/1ps

module csrs_mem_model (
  input  wire logic                 i_ref_clk,
  input  wire logic                 i_reset,
  input  wire logic                 i_eclk,
  input  wire csrs_pkg::csrs_pins_t i_pins,
  output logic                      o_done,
  output csrs_pkg::csrs_pins_t      o_pins_seen,
  output logic [7:0]                o_high_len
);
  logic [7:0]           hi_cnt;
  csrs_pkg::csrs_pins_t pins_q;

  // a slow part sees the whole stretched high phase as one access
  always_ff @(posedge i_ref_clk) begin
    o_done <= 1'b0;
    if (i_reset) begin
      hi_cnt      <= 8'h00;
      pins_q      <= csrs_pkg::PINS_RESET;
      o_pins_seen <= csrs_pkg::PINS_RESET;
      o_high_len  <= 8'h00;
    end else if (i_eclk) begin
      hi_cnt <= hi_cnt + 8'h01;
      pins_q <= i_pins;
    end else if (hi_cnt != 8'h00) begin
      o_done      <= 1'b1;
      o_pins_seen <= pins_q;
      o_high_len  <= hi_cnt;
      hi_cnt      <= 8'h00;
    end
  end
endmodule : csrs_mem_model

// ===== tb/testbench.sv
// Purpose: self-checking bench for chip-select routing and stretching
// Assumes: ECLK_HALF of 2, apb slave without wait states
// Notes:   bus cycle results come from the memory model's reports

`timescale 1ns/1ps

module testbench;
  localparam int HALF = 2;
  typedef struct packed {
    csrs_pkg::csrs_pins_t pins;
    logic [7:0]           len;
  } csrs_note_t;
  logic                    clk = 1'b0;
  logic                    rst = 1'b1;
  csrs_pkg::csrs_apb_req_t apb = '0;
  csrs_pkg::csrs_apb_rsp_t rsp;
  logic                    acc = 1'b0;
  csrs_pkg::csrs_sel_t     hit = '0;
  logic                    eclk, start, tick, done;
  csrs_pkg::csrs_pins_t    pins, seen;
  logic [7:0]              hlen, st, c1, c2;
  csrs_note_t              notes[$];
  csrs_note_t              nt;
  int                      miscompares = 0;
  int                      n_checks = 0;

  always #2.5 clk = ~clk;

  csrs_top #(.ECLK_HALF(HALF)) dut_u (.i_ref_clk(clk), .i_reset(rst),
    .i_apb(apb), .o_apb(rsp), .i_access(acc), .i_range_hit(hit),
    .o_eclk(eclk), .o_bus_cycle_start(start), .o_timer_tick(tick),
    .o_pins(pins));
  csrs_mem_model mem_u (.i_ref_clk(clk), .i_reset(rst), .i_eclk(eclk),
    .i_pins(pins), .o_done(done), .o_pins_seen(seen), .o_high_len(hlen));

  task automatic check(input string what, input logic [31:0] sv,
                       input logic [31:0] ev);
    n_checks++;
    if (sv !== ev) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, ev, sv);
    end
  endtask : check

  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : stop_test

  task automatic timed_out();
    miscompares++;
    $display("Error wait expected done seen timeout");
    stop_test();
  endtask : timed_out

  // ****************************************
  // apb master
  // ****************************************
  task automatic apb_xfer(input logic wr, input logic [11:0] a,
                          input logic [7:0] wd, output logic [31:0] rd,
                          output logic err);
    @(posedge clk);
    apb.psel    <= 1'b1;
    apb.penable <= 1'b0;
    apb.pwrite  <= wr;
    apb.paddr   <= a;
    apb.pwdata  <= {24'h000000, wd};
    @(posedge clk);
    apb.penable <= 1'b1;
    for (int k = 0; k < 16; k++) begin
      @(posedge clk);
      if (rsp.pready === 1'b1) begin
        rd = rsp.prdata;
        err = rsp.pslverr;
        apb.psel    <= 1'b0;
        apb.penable <= 1'b0;
        return;
      end
    end
    timed_out();
  endtask : apb_xfer

  task automatic reg_rd(input logic [11:0] a, input logic [7:0] e,
                        input logic ee);
    logic [31:0] rd;
    logic        err;
    apb_xfer(1'b0, a, 8'h00, rd, err);
    check("prdata", rd, {24'h000000, e});
    check("pslverr", {31'h0, err}, {31'h0, ee});
  endtask : reg_rd

  task automatic cfg(input logic [7:0] s, input logic [7:0] a,
                     input logic [7:0] b);
    logic [31:0] rd;
    logic        err;
    apb_xfer(1'b1, csrs_pkg::ADDR_STRETCH, s, rd, err);
    apb_xfer(1'b1, csrs_pkg::ADDR_GEN1_CTRL, a, rd, err);
    apb_xfer(1'b1, csrs_pkg::ADDR_GEN2_CTRL, b, rd, err);
    st = s;
    c1 = a & 8'he0;
    c2 = b & 8'h60;
    reg_rd(csrs_pkg::ADDR_STRETCH, st, 1'b0);
    reg_rd(csrs_pkg::ADDR_GEN1_CTRL, c1, 1'b0);
    reg_rd(csrs_pkg::ADDR_GEN2_CTRL, c2, 1'b0);
  endtask : cfg

  // ****************************************
  // bus cycles and expectations
  // ****************************************
  function automatic csrs_note_t expect_cyc(input logic a,
                                            input csrs_pkg::csrs_sel_t h);
    csrs_pkg::csrs_sel_t c;
    logic                pa, p1, p2;
    logic [1:0]          n;
    csrs_note_t          r;
    c = '0;
    if (a) begin
      if (h.io) c.io = 1'b1;
      else if (h.gen1) c.gen1 = 1'b1;
      else if (h.gen2) c.gen2 = 1'b1;
      else c.prog = h.prog;
    end
    pa = c.prog | (c1[6] & c.gen1) | (c2[6] & c.gen2);
    p2 = (c.gen2 & !c2[6]) | (c.gen1 & c1[7] & !c1[6] & !c2[6]);
    p1 = c.gen1 & !c1[6] & !(c1[7] & !c2[6]);
    n = c.io ? st[7:6] : c.gen1 ? st[5:4] : c.gen2 ? st[3:2] : st[1:0];
    r.pins = {!pa, c1[5] ~^ p1, c2[5] ~^ p2, !c.io};
    r.len  = 8'(HALF + 2 * HALF * int'(c == '0 ? 2'h0 : n));
    return r;
  endfunction : expect_cyc

  task automatic wait_lvl(input logic on_eclk);
    for (int k = 0; k < 100; k++) begin
      @(negedge clk);
      if ((on_eclk ? eclk : start) === 1'b1) return;
    end
    timed_out();
  endtask : wait_lvl

  // note goes in once eclk is high, after the last report has gone out
  task automatic run_cyc(input logic a, input csrs_pkg::csrs_sel_t h);
    @(posedge clk);
    acc <= a;
    hit <= h;
    wait_lvl(1'b0);
    @(posedge clk);
    wait_lvl(1'b1);
    notes.push_back(expect_cyc(a, h));
  endtask : run_cyc

  always @(negedge clk) begin
    if (done === 1'b1 && notes.size() > 0) begin
      nt = notes.pop_front();
      check("pins", {28'h0, seen}, {28'h0, nt.pins});
      check("high_len", {24'h0, hlen}, {24'h0, nt.len});
    end
  end

  initial begin
    csrs_pkg::csrs_sel_t h;
    logic [7:0]          s;
    logic [31:0]         rd;
    logic                err;
    void'($urandom(45965));
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    check("pins_reset", {28'h0, pins}, {28'h0, csrs_pkg::PINS_RESET});
    reg_rd(csrs_pkg::ADDR_STRETCH, 8'h00, 1'b0);
    reg_rd(csrs_pkg::ADDR_GEN1_CTRL, 8'h00, 1'b0);
    reg_rd(csrs_pkg::ADDR_GEN2_CTRL, 8'h00, 1'b0);
    reg_rd(12'h004, 8'h00, 1'b1);
    apb_xfer(1'b0, csrs_pkg::ADDR_STATUS, 8'h00, rd, err);
    check("status", rd & 32'h7f, 32'h0);
    check("status_err", {31'h0, err}, 32'h0);
    $display("test reset done");
    for (int m = 0; m < 8; m++) begin
      s = (m == 0) ? 8'h1b : (m == 1) ? 8'he4 : 8'($urandom);
      cfg(s, {m[2], m[1], 6'($urandom)}, {1'($urandom), m[0], 6'($urandom)});
      for (int k = 0; k < 6; k++) begin
        h = csrs_pkg::csrs_sel_t'(k < 4 ? 4'h1 << k : k == 4 ? 4'h4 : 4'hf);
        run_cyc(k != 4, h);
      end
      $display("test route %0d done", m);
    end
    for (int k = 0; k < 100 && notes.size() > 0; k++) @(negedge clk);
    check("notes_left", notes.size(), 32'h0);
    $display("test drain done");
    apb_xfer(1'b1, csrs_pkg::ADDR_STRETCH, 8'hff, rd, err);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    check("pins_reset", {28'h0, pins}, {28'h0, csrs_pkg::PINS_RESET});
    reg_rd(csrs_pkg::ADDR_STRETCH, 8'h00, 1'b0);
    $display("test second reset done");
    stop_test();
  end
endmodule : testbench
